// File: core/rx_engine_pkg.sv
package rx_engine_pkg;

   // ---------------------------------------------
   // Command codes
   // ---------------------------------------------
   localparam logic [5:0] CMD_IDLE       = 6'h00;
   localparam logic [5:0] CMD_RECEIVE    = 6'h16;
   localparam logic [5:0] CMD_TRANSCEIVE = 6'h1E;

   // ---------------------------------------------
   // Link phase codes
   // ---------------------------------------------
   localparam logic [2:0] PH_IDLE  = 3'h0;
   localparam logic [2:0] PH_GORX  = 3'h4;
   localparam logic [2:0] PH_DELAY = 3'h5;
   localparam logic [2:0] PH_WAIT  = 3'h6;
   localparam logic [2:0] PH_RECV  = 3'h7;

   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int BIT_PERIOD_NS = 9440;
   localparam int BIT_CYCLES    = BIT_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] PREP_TOP = 8'h03;

   // ---------------------------------------------
   // Check block
   // ---------------------------------------------
   localparam logic [15:0] CRC16_POLY   = 16'h8408;
   localparam logic [15:0] CRC16_PRESET = 16'h6363;
   localparam logic [7:0]  SHORT_CHECK_SELECT_POLY    = 8'hB8;
   localparam logic [7:0]  SHORT_CHECK_SELECT_PRESET  = 8'hFF;
   localparam logic [2:0]  LAST_BIT     = 3'h7;
   localparam logic [2:0]  ONE_BIT_OFS  = 3'h7;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'b000_0001,
      ST_TXW   = 7'b000_0010,
      ST_GOIN  = 7'b000_0100,
      ST_DELAY = 7'b000_1000,
      ST_AWAIT = 7'b001_0000,
      ST_RECV  = 7'b010_0000,
      ST_GOOUT = 7'b100_0000
   } phase_t;

endpackage

// File: core/rx_check_unit.sv
`timescale 1ns/1ps
module rx_check_unit (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       init,
   input  wire logic       byteEn,
   input  wire logic [7:0] byteIn,
   input  wire logic       shortSel,
   output logic            residueZero
);
   logic [15:0] crc_ff;
   logic [15:0] nxt_crc16;
   logic [7:0]  nxt_short_check_select;

   // Running the check over data and its own check bytes leaves zero
   always_comb begin
      nxt_crc16 = crc_ff;
      nxt_short_check_select  = crc_ff[7:0];
      for (int i = 0; i < 8; i++) begin
         if (nxt_crc16[0] ^ byteIn[i]) begin
            nxt_crc16 = (nxt_crc16 >> 1) ^ rx_engine_pkg::CRC16_POLY;
         end else begin
            nxt_crc16 = nxt_crc16 >> 1;
         end
         if (nxt_short_check_select[0] ^ byteIn[i]) begin
            nxt_short_check_select = (nxt_short_check_select >> 1) ^ rx_engine_pkg::SHORT_CHECK_SELECT_POLY;
         end else begin
            nxt_short_check_select = nxt_short_check_select >> 1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         crc_ff <= 16'h0000;
      end else if (init) begin
         crc_ff <= shortSel ? {8'h00, rx_engine_pkg::SHORT_CHECK_SELECT_PRESET}
                            : rx_engine_pkg::CRC16_PRESET;
      end else if (byteEn) begin
         crc_ff <= shortSel ? {8'h00, nxt_short_check_select} : nxt_crc16;
      end
   end

   assign residueZero = shortSel ? (crc_ff[7:0] == 8'h00)
                                 : (crc_ff == 16'h0000);
endmodule

// File: core/contactless_receive_engine.sv
`timescale 1ns/1ps
module contactless_receive_engine #(
   parameter int BIT_CYCLES = rx_engine_pkg::BIT_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       cmdWrite,
   input  wire logic [5:0] cmdCode,
   input  wire logic       txDone,
   input  wire logic [1:0] txPhaseCode,
   input  wire logic [7:0] receiverDelayCount,
   input  wire logic [3:0] signalFloorLevel,
   input  wire logic [3:0] clashAmplitudeLevel,
   input  wire logic       inboundCheckEnable,
   input  wire logic       shortCheckSelect,
   input  wire logic       parityCheckEnable,
   input  wire logic       oddParitySelect,
   input  wire logic       clearBitsAfterClash,
   input  wire logic [2:0] inboundBitOffset,
   input  wire logic [3:0] sigStrength,
   input  wire logic       symStrobe,
   input  wire logic       symSof,
   input  wire logic       symEof,
   input  wire logic [3:0] ampFirst,
   input  wire logic [3:0] ampSecond,
   input  wire logic       rxDoneClear,
   input  wire logic       cmdDoneClear,
   output logic [5:0]      activeCommand,
   output logic [2:0]      linkPhaseCode,
   output logic            frontEndPrep,
   output logic            monitorOn,
   output logic            fifoWrValid,
   output logic [7:0]      fifoWrData,
   output logic            receiveDoneFlag,
   output logic            commandDoneFlag,
   output logic            clashErrorFlag,
   output logic            parityFaultFlag,
   output logic            frameFaultFlag,
   output logic            checksumFaultFlag,
   output logic [7:0]      firstClashPosition,
   output logic [2:0]      finalByteValidBits,
   output logic            offsetClearPulse
);
   if (BIT_CYCLES < 1 || BIT_CYCLES > 65536) begin : g_chk
      $error("BIT_CYCLES must be at least 1");
   end

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   rx_engine_pkg::phase_t state_ff;
   logic [7:0]  delayCnt_ff;
   logic [15:0] divCnt_ff;
   logic        bitClkEn;
   logic        flushDone;
   logic        abortCmd;
   logic        startRx;
   logic        sigGone;
   logic        endNow;
   logic        finishCmd;

   assign abortCmd  = cmdWrite && (cmdCode == rx_engine_pkg::CMD_IDLE);
   assign startRx   = (state_ff == rx_engine_pkg::ST_GOIN);
   assign sigGone   = (sigStrength <= signalFloorLevel);
   assign endNow    = (state_ff == rx_engine_pkg::ST_RECV) &&
                      ((symStrobe && symEof) || sigGone);
   assign finishCmd = (state_ff == rx_engine_pkg::ST_GOOUT) && flushDone
                      && !abortCmd;
   assign bitClkEn  = (divCnt_ff == 16'h0000);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= rx_engine_pkg::ST_IDLE;
      end else if (abortCmd) begin
         state_ff <= rx_engine_pkg::ST_IDLE;
      end else begin
         case (state_ff)
            rx_engine_pkg::ST_IDLE: begin
               if (cmdWrite && cmdCode == rx_engine_pkg::CMD_RECEIVE) begin
                  state_ff <= rx_engine_pkg::ST_GOIN;
               end else if (cmdWrite &&
                            cmdCode == rx_engine_pkg::CMD_TRANSCEIVE) begin
                  state_ff <= rx_engine_pkg::ST_TXW;
               end
            end
            rx_engine_pkg::ST_TXW: begin
               if (txDone) begin
                  state_ff <= rx_engine_pkg::ST_GOIN;
               end
            end
            rx_engine_pkg::ST_GOIN: begin
               state_ff <= rx_engine_pkg::ST_DELAY;
            end
            rx_engine_pkg::ST_DELAY: begin
               if (delayCnt_ff == 8'h00) begin
                  state_ff <= rx_engine_pkg::ST_AWAIT;
               end
            end
            rx_engine_pkg::ST_AWAIT: begin
               if (!sigGone) begin
                  state_ff <= rx_engine_pkg::ST_RECV;
               end
            end
            rx_engine_pkg::ST_RECV: begin
               if (endNow) begin
                  state_ff <= rx_engine_pkg::ST_GOOUT;
               end
            end
            rx_engine_pkg::ST_GOOUT: begin
               if (flushDone) begin
                  state_ff <= rx_engine_pkg::ST_IDLE;
               end
            end
            default: state_ff <= rx_engine_pkg::ST_IDLE;
         endcase
      end
   end

   // Bit-clock divider restarts on entry so the first tick is a full bit
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         divCnt_ff <= 16'h0000;
      end else if (startRx || bitClkEn) begin
         divCnt_ff <= 16'(BIT_CYCLES - 1);
      end else begin
         divCnt_ff <= divCnt_ff - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         delayCnt_ff <= 8'h00;
      end else if (startRx) begin
         delayCnt_ff <= receiverDelayCount;
      end else if (state_ff == rx_engine_pkg::ST_DELAY && bitClkEn &&
                   delayCnt_ff != 8'h00) begin
         delayCnt_ff <= delayCnt_ff - 8'h01;
      end
   end

   // ---------------------------------------------
   // Reporting outputs
   // ---------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         linkPhaseCode <= rx_engine_pkg::PH_IDLE;
         frontEndPrep  <= 1'b0;
         monitorOn     <= 1'b0;
      end else begin
         case (state_ff)
            rx_engine_pkg::ST_TXW:   linkPhaseCode <= {1'b0, txPhaseCode};
            rx_engine_pkg::ST_GOIN:  linkPhaseCode <= rx_engine_pkg::PH_GORX;
            rx_engine_pkg::ST_DELAY: linkPhaseCode <= rx_engine_pkg::PH_DELAY;
            rx_engine_pkg::ST_AWAIT: linkPhaseCode <= rx_engine_pkg::PH_WAIT;
            rx_engine_pkg::ST_RECV:  linkPhaseCode <= rx_engine_pkg::PH_RECV;
            rx_engine_pkg::ST_GOOUT: linkPhaseCode <= rx_engine_pkg::PH_GORX;
            default:                 linkPhaseCode <= rx_engine_pkg::PH_IDLE;
         endcase
         frontEndPrep <= (state_ff == rx_engine_pkg::ST_DELAY) &&
                         (delayCnt_ff != 8'h00) &&
                         (delayCnt_ff <= rx_engine_pkg::PREP_TOP);
         monitorOn <= (state_ff == rx_engine_pkg::ST_AWAIT) ||
                      (state_ff == rx_engine_pkg::ST_RECV);
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         receiveDoneFlag  <= 1'b0;
         commandDoneFlag  <= 1'b0;
         activeCommand    <= rx_engine_pkg::CMD_IDLE;
         offsetClearPulse <= 1'b0;
      end else begin
         offsetClearPulse <= finishCmd;
         if (finishCmd) begin
            receiveDoneFlag <= 1'b1;
            commandDoneFlag <= 1'b1;
         end else begin
            if (rxDoneClear) receiveDoneFlag <= 1'b0;
            if (cmdDoneClear) commandDoneFlag <= 1'b0;
         end
         if (abortCmd || finishCmd) begin
            activeCommand <= rx_engine_pkg::CMD_IDLE;
         end else if (state_ff == rx_engine_pkg::ST_IDLE && cmdWrite &&
                      (cmdCode == rx_engine_pkg::CMD_RECEIVE ||
                       cmdCode == rx_engine_pkg::CMD_TRANSCEIVE)) begin
            activeCommand <= cmdCode;
         end
      end
   end

   // ---------------------------------------------
   // Bit decoding and byte assembly
   // ---------------------------------------------
   logic       sofDone_ff, sofBad_ff, clashSeen_ff;
   logic       parExp_ff, parAcc_ff, skipPar_ff, firstByte_ff;
   logic [2:0] bitIdx_ff;
   logic [7:0] byteBuf_ff, partial_ff, hold0_ff, hold1_ff, byteCnt_ff;
   logic [7:0] posCnt_ff;
   logic [1:0] holdCnt_ff, flushLeft_ff;
   logic       partialPend_ff;
   logic       clashNow, rawBit, bitVal, dataBit, parBit, expPar;
   logic       pushReq, residueZero, crcBad;
   logic [7:0] nxt_byte;
   logic [1:0] crcLen;
   logic [3:0] weaker;

   assign weaker  = (ampFirst < ampSecond) ? ampFirst : ampSecond;
   assign clashNow = (ampFirst > signalFloorLevel) &&
                     (ampSecond > signalFloorLevel) &&
                     (weaker > clashAmplitudeLevel);
   assign rawBit  = clashNow || (ampFirst > ampSecond);
   assign bitVal  = (clearBitsAfterClash && clashSeen_ff) ? 1'b0
                                                          : rawBit;
   assign dataBit = (state_ff == rx_engine_pkg::ST_RECV) && symStrobe &&
                    !symSof && !symEof && !sigGone && sofDone_ff &&
                    !parExp_ff;
   assign parBit  = (state_ff == rx_engine_pkg::ST_RECV) && symStrobe &&
                    !symSof && !symEof && !sigGone && parExp_ff;
   assign expPar  = oddParitySelect ? !parAcc_ff : parAcc_ff;
   assign nxt_byte = byteBuf_ff | (8'h01 << bitIdx_ff);
   assign pushReq = dataBit && (bitIdx_ff == rx_engine_pkg::LAST_BIT) &&
                    !sofBad_ff && !(firstByte_ff &&
                    inboundBitOffset == rx_engine_pkg::ONE_BIT_OFS);
   assign crcLen  = shortCheckSelect ? 2'd1 : 2'd2;
   assign crcBad  = inboundCheckEnable &&
                    ({6'h00, crcLen} > byteCnt_ff || !residueZero);
   assign flushDone = (flushLeft_ff == 2'd0) && !partialPend_ff;

   rx_check_unit u_check (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .init        (startRx),
      .byteEn      (pushReq),
      .byteIn      (bitVal ? nxt_byte : byteBuf_ff),
      .shortSel    (shortCheckSelect),
      .residueZero (residueZero)
   );

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sofDone_ff <= 1'b0;
         sofBad_ff <= 1'b0;
         clashSeen_ff <= 1'b0;
         parExp_ff <= 1'b0;
         parAcc_ff <= 1'b0;
         skipPar_ff <= 1'b0;
         firstByte_ff <= 1'b0;
         bitIdx_ff <= 3'h0;
         byteBuf_ff <= 8'h00;
         posCnt_ff <= 8'h00;
         clashErrorFlag <= 1'b0;
         parityFaultFlag <= 1'b0;
         frameFaultFlag <= 1'b0;
         firstClashPosition <= 8'h00;
      end else if (startRx) begin
         sofDone_ff <= 1'b0;
         sofBad_ff <= 1'b0;
         clashSeen_ff <= 1'b0;
         parExp_ff <= 1'b0;
         skipPar_ff <= (inboundBitOffset != 3'h0);
         firstByte_ff <= 1'b1;
         bitIdx_ff <= inboundBitOffset;
         byteBuf_ff <= 8'h00;
         posCnt_ff <= 8'h00;
         clashErrorFlag <= 1'b0;
         parityFaultFlag <= 1'b0;
         frameFaultFlag <= 1'b0;
         firstClashPosition <= 8'h00;
      end else if (state_ff == rx_engine_pkg::ST_RECV && symStrobe &&
                   !sigGone) begin
         if (symSof && !sofDone_ff) begin
            sofDone_ff <= 1'b1;
            if (clashNow) begin
               sofBad_ff <= 1'b1;
               frameFaultFlag <= 1'b1;
               clashErrorFlag <= 1'b1;
               clashSeen_ff <= 1'b1;
               firstClashPosition <= 8'h00;
            end
         end else if (!symEof && !sofDone_ff) begin
            frameFaultFlag <= 1'b1;
            sofDone_ff <= 1'b1;
            sofBad_ff <= 1'b1;
         end else if (parBit) begin
            parExp_ff <= 1'b0;
            skipPar_ff <= 1'b0;
            if (clashNow) begin
               parityFaultFlag <= 1'b1;
               clashErrorFlag <= 1'b1;
            end else if (!skipPar_ff && rawBit != expPar) begin
               parityFaultFlag <= 1'b1;
            end
         end else if (dataBit) begin
            if (posCnt_ff != 8'hFF) begin
               posCnt_ff <= posCnt_ff + 8'h01;
            end
            if (clashNow) begin
               clashErrorFlag <= 1'b1;
               clashSeen_ff <= 1'b1;
               if (!clashSeen_ff) begin
                  firstClashPosition <= posCnt_ff + 8'h01;
               end
            end
            if (bitIdx_ff == rx_engine_pkg::LAST_BIT) begin
               bitIdx_ff <= 3'h0;
               byteBuf_ff <= 8'h00;
               firstByte_ff <= 1'b0;
               parExp_ff <= parityCheckEnable;
               parAcc_ff <= ^(bitVal ? nxt_byte : byteBuf_ff);
            end else begin
               bitIdx_ff <= bitIdx_ff + 3'h1;
               if (bitVal) byteBuf_ff <= nxt_byte;
            end
         end
      end
   end

   // ---------------------------------------------
   // Check-block delay buffer and FIFO writes
   // ---------------------------------------------
   // A partial byte is written last and never enters the check window
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hold0_ff <= 8'h00;
         hold1_ff <= 8'h00;
         holdCnt_ff <= 2'd0;
         byteCnt_ff <= 8'h00;
         flushLeft_ff <= 2'd0;
         partialPend_ff <= 1'b0;
         partial_ff <= 8'h00;
         fifoWrValid <= 1'b0;
         fifoWrData <= 8'h00;
         checksumFaultFlag <= 1'b0;
         finalByteValidBits <= 3'h0;
      end else begin
         fifoWrValid <= 1'b0;
         if (startRx) begin
            holdCnt_ff <= 2'd0;
            byteCnt_ff <= 8'h00;
            flushLeft_ff <= 2'd0;
            partialPend_ff <= 1'b0;
            checksumFaultFlag <= 1'b0;
            finalByteValidBits <= 3'h0;
         end else if (pushReq) begin
            if (byteCnt_ff != 8'hFF) byteCnt_ff <= byteCnt_ff + 8'h01;
            if (!inboundCheckEnable) begin
               fifoWrValid <= 1'b1;
               fifoWrData <= bitVal ? nxt_byte : byteBuf_ff;
            end else begin
               if (holdCnt_ff == crcLen) begin
                  fifoWrValid <= 1'b1;
                  fifoWrData <= hold0_ff;
               end else begin
                  holdCnt_ff <= holdCnt_ff + 2'd1;
               end
               if (crcLen == 2'd1) begin
                  hold0_ff <= bitVal ? nxt_byte : byteBuf_ff;
               end else if (holdCnt_ff == 2'd0) begin
                  hold0_ff <= bitVal ? nxt_byte : byteBuf_ff;
               end else begin
                  hold0_ff <= (holdCnt_ff == 2'd1) ? hold0_ff : hold1_ff;
                  hold1_ff <= bitVal ? nxt_byte : byteBuf_ff;
               end
            end
         end else if (endNow) begin
            checksumFaultFlag <= crcBad;
            flushLeft_ff <= (crcBad && !sofBad_ff) ? holdCnt_ff : 2'd0;
            partialPend_ff <= !sofBad_ff && sofDone_ff &&
                              bitIdx_ff != 3'h0 && !parExp_ff &&
                              !(firstByte_ff && bitIdx_ff <=
                                inboundBitOffset);
            partial_ff <= byteBuf_ff;
            finalByteValidBits <= parExp_ff ? 3'h0 : bitIdx_ff;
         end else if (state_ff == rx_engine_pkg::ST_GOOUT) begin
            if (flushLeft_ff != 2'd0) begin
               fifoWrValid <= 1'b1;
               fifoWrData <= hold0_ff;
               hold0_ff <= hold1_ff;
               flushLeft_ff <= flushLeft_ff - 2'd1;
            end else if (partialPend_ff) begin
               fifoWrValid <= 1'b1;
               fifoWrData <= partial_ff;
               partialPend_ff <= 1'b0;
            end
         end
      end
   end
endmodule

// File: verif/rx_engine_assertions.sv
`timescale 1ns/1ps
module rx_engine_assertions (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       cmdWrite,
   input wire logic [5:0] cmdCode,
   input wire logic [5:0] activeCommand,
   input wire logic [2:0] linkPhaseCode,
   input wire logic       frontEndPrep,
   input wire logic       monitorOn,
   input wire logic       fifoWrValid,
   input wire logic       receiveDoneFlag,
   input wire logic       commandDoneFlag,
   input wire logic       clashErrorFlag,
   input wire logic       frameFaultFlag,
   input wire logic       offsetClearPulse
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (reset);
   AST_CMD_TAKE: assert property (cmdWrite && activeCommand == '0 &&
      cmdCode == rx_engine_pkg::CMD_RECEIVE |=>
      activeCommand == rx_engine_pkg::CMD_RECEIVE) else $error("cmd lost");
   AST_CMD_PHASE: assert property (
      $rose(activeCommand == rx_engine_pkg::CMD_RECEIVE) |=>
      linkPhaseCode == rx_engine_pkg::PH_GORX) else $error("no start phase");
   AST_IDLE_ABORT: assert property (cmdWrite && cmdCode == '0 |=>
      activeCommand == '0 && !$rose(commandDoneFlag)) else $error("abort");
   AST_PREP_END: assert property ($fell(frontEndPrep) &&
      activeCommand != '0 |-> ##[0:1] monitorOn) else $error("no monitor");
   AST_DONE_SET: assert property ($rose(receiveDoneFlag) |->
      commandDoneFlag && offsetClearPulse && activeCommand == '0)
      else $error("done report wrong");
   AST_OFS_PULSE: assert property (offsetClearPulse |=>
      !offsetClearPulse) else $error("offset clear not a pulse");
   AST_SOF_CLASH: assert property (frameFaultFlag &&
      clashErrorFlag |-> !fifoWrValid) else $error("data after bad start");
   AST_FLAG_CLEAR: assert property (
      $rose(activeCommand == rx_engine_pkg::CMD_RECEIVE) |=>
      !clashErrorFlag && !frameFaultFlag) else $error("stale fault flags");
endmodule

bind contactless_receive_engine rx_engine_assertions i_chk (
   .clk_sys(clk_sys), .reset(reset), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
   .activeCommand(activeCommand), .linkPhaseCode(linkPhaseCode),
   .frontEndPrep(frontEndPrep), .monitorOn(monitorOn),
   .fifoWrValid(fifoWrValid), .receiveDoneFlag(receiveDoneFlag),
   .commandDoneFlag(commandDoneFlag), .clashErrorFlag(clashErrorFlag),
   .frameFaultFlag(frameFaultFlag), .offsetClearPulse(offsetClearPulse));

// File: verif/card_front_model.sv
`timescale 1ns/1ps
module card_front_model (
   input  wire logic       clk_sys,
   output logic [3:0]      sigStrength,
   output logic            symStrobe,
   output logic            symSof,
   output logic            symEof,
   output logic [3:0]      ampFirst,
   output logic [3:0]      ampSecond
);
   initial {sigStrength, symStrobe, symSof, symEof, ampFirst, ampSecond} = '0;
   // k = {sof, eof, bit, clash}; level rises three cycles before first symbol
   task automatic sym(input logic [3:0] k);
      if (sigStrength == 4'h0) begin
         sigStrength <= 4'hA;
         repeat (2) @(negedge clk_sys);
      end
      @(negedge clk_sys);
      {symStrobe, symSof, symEof} <= {1'h1, k[3:2]};
      ampFirst <= (k[1] | k[0]) ? 4'hC : 4'h1;
      ampSecond <= k[0] ? 4'hB : (k[1] ? 4'h1 : 4'hC);
      @(negedge clk_sys);
      {symStrobe, symSof, symEof} <= 3'h0;
      // Scrambled between strobes so a stale sample cannot look valid
      ampFirst <= ~ampFirst;
      ampSecond <= ~ampSecond;
      if (k[2]) sigStrength <= 4'h0;
   endtask
   task automatic bits(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) sym({2'h0, v[i], 1'h0});
   endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic       clk_sys, reset, cmdWrite, txDone, rxDoneClear, cmdDoneClear;
   logic       inboundCheckEnable, parityCheckEnable, oddParitySelect;
   logic       clearBitsAfterClash, symStrobe, symSof, symEof, frontEndPrep;
   logic       monitorOn, fifoWrValid, receiveDoneFlag, commandDoneFlag;
   logic       clashErrorFlag, parityFaultFlag, frameFaultFlag;
   logic       checksumFaultFlag, offsetClearPulse, shortCheckSelect;
   logic [1:0] txPhaseCode;
   logic [15:0] cc;
   logic [2:0] inboundBitOffset, linkPhaseCode, finalByteValidBits;
   logic [3:0] sigStrength, ampFirst, ampSecond;
   logic [5:0] cmdCode, activeCommand;
   logic [7:0] fifoWrData, firstClashPosition, d0, d1, receiverDelayCount, q[$];
   int         err_count, checks, cyc, seed;
   contactless_receive_engine #(.BIT_CYCLES(4)) i_contactless_receive_engine (
      .clk_sys, .reset, .cmdWrite, .cmdCode, .txDone, .txPhaseCode,
      .receiverDelayCount, .signalFloorLevel(4'h3),
      .clashAmplitudeLevel(4'h8), .inboundCheckEnable, .shortCheckSelect,
      .parityCheckEnable, .oddParitySelect, .clearBitsAfterClash,
      .inboundBitOffset, .sigStrength, .symStrobe, .symSof, .symEof, .ampFirst,
      .ampSecond, .rxDoneClear, .cmdDoneClear, .activeCommand, .linkPhaseCode,
      .frontEndPrep, .monitorOn, .fifoWrValid, .fifoWrData, .receiveDoneFlag,
      .commandDoneFlag, .clashErrorFlag, .parityFaultFlag, .frameFaultFlag,
      .checksumFaultFlag, .firstClashPosition, .finalByteValidBits,
      .offsetClearPulse);
   card_front_model i_card_front_model (.clk_sys, .sigStrength, .symStrobe,
      .symSof, .symEof, .ampFirst, .ampSecond);
   task automatic check(input logic [7:0] got, exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   function automatic logic [15:0] crc(input logic [15:0] d, input logic s);
      logic [15:0] r, p;
      r = s ? {8'h00, rx_engine_pkg::SHORT_CHECK_SELECT_PRESET}
            : rx_engine_pkg::CRC16_PRESET;
      p = s ? {8'h00, rx_engine_pkg::SHORT_CHECK_SELECT_POLY} : rx_engine_pkg::CRC16_POLY;
      for (int i = 0; i < 16; i++)
         r = (r[0] ^ d[i]) ? (r >> 1) ^ p : r >> 1;
      return r;
   endfunction
   task automatic cmd(input logic [5:0] code);
      @(negedge clk_sys);
      {cmdWrite, cmdCode} = {1'h1, code};
      @(negedge clk_sys);
      cmdWrite = 1'h0;
   endtask
   task automatic begin_rx(input logic [5:0] code, input logic sofClash);
      cmd(code);
      txDone = (code == rx_engine_pkg::CMD_TRANSCEIVE);
      @(negedge clk_sys);
      check({5'h00, linkPhaseCode}, txDone ? {6'h00, txPhaseCode} :
         {5'h00, rx_engine_pkg::PH_GORX});
      check({2'h0, activeCommand}, {2'h0, code});
      txDone = 1'h0;
      for (int i = 0; i < 300 && !monitorOn; i++) @(negedge clk_sys);
      i_card_front_model.sym({3'h4, sofClash});
   endtask
   task automatic sbyte(input logic [7:0] d);
      i_card_front_model.bits(d, 8);
      if (parityCheckEnable)
         i_card_front_model.sym({2'h0, ^d ^ oddParitySelect, 1'h0});
   endtask
   task automatic end_rx(input logic [7:0] flags, pos);
      i_card_front_model.sym(4'h4);
      for (int i = 0; i < 300 && !receiveDoneFlag; i++) @(negedge clk_sys);
      check({clashErrorFlag, parityFaultFlag, frameFaultFlag,
         checksumFaultFlag, receiveDoneFlag, finalByteValidBits}, flags);
      check(firstClashPosition, pos);
      check(8'(q.size()), 8'h00);
      {rxDoneClear, cmdDoneClear} = 2'h3;
      @(negedge clk_sys);
      {rxDoneClear, cmdDoneClear} = 2'h0;
   endtask
   always @(negedge clk_sys)
      if (fifoWrValid)
         check(fifoWrData, q.size() ? q.pop_front() : 8'hxx);
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      {cmdWrite, cmdCode, txDone, rxDoneClear, cmdDoneClear} = '0;
      {inboundCheckEnable, clearBitsAfterClash, inboundBitOffset} = '0;
      {reset, parityCheckEnable, seed} = {2'h3, 32'h5dc9};
      oddParitySelect = 1'($random(seed));
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      shortCheckSelect = 1'h1;
      txPhaseCode = 2'($random(seed));
      receiverDelayCount = 8'h03 + {6'h00, 2'($random(seed))};
      repeat (6) @(negedge clk_sys);
      reset = 1'h0;
      q = '{d0, d1};
      begin_rx(rx_engine_pkg::CMD_RECEIVE, 1'h0);
      sbyte(d0);
      sbyte(d1);
      end_rx(8'h08, 8'h00);
      inboundCheckEnable = 1'h1;
      // Good block stays withheld; a corrupted one is written out
      for (int k = 0; k < 4; k++) begin
         shortCheckSelect = !k[1];
         cc = crc({d1, d0}, !k[1]) ^ 16'(k[0]);
         q = '{d0, d1};
         if (k[0]) q.push_back(cc[7:0]);
         if (k[0] && k[1]) q.push_back(cc[15:8]);
         begin_rx(rx_engine_pkg::CMD_TRANSCEIVE, 1'h0);
         sbyte(d0);
         sbyte(d1);
         sbyte(cc[7:0]);
         if (k[1]) sbyte(cc[15:8]);
         end_rx(k[0] ? 8'h18 : 8'h08, 8'h00);
      end
      {inboundCheckEnable, parityCheckEnable, clearBitsAfterClash} = 3'h1;
      q = '{{5'h01, d0[2:0]}, 8'h00};
      begin_rx(rx_engine_pkg::CMD_RECEIVE, 1'h0);
      i_card_front_model.bits(d0, 3);
      i_card_front_model.sym(4'h1);
      i_card_front_model.bits(d1, 4);
      sbyte(d1);
      end_rx(8'h88, 8'h04);
      begin_rx(rx_engine_pkg::CMD_RECEIVE, 1'h1);
      sbyte(d0);
      end_rx(8'hA8, 8'h00);
      {parityCheckEnable, clearBitsAfterClash, inboundBitOffset} = 5'h17;
      q = '{d1, {5'h00, d0[2:0]}};
      begin_rx(rx_engine_pkg::CMD_RECEIVE, 1'h0);
      i_card_front_model.bits(d0, 2);
      sbyte(d1);
      i_card_front_model.bits(d0, 3);
      end_rx(8'h0B, 8'h00);
      inboundBitOffset = 3'h0;
      cmd(rx_engine_pkg::CMD_RECEIVE);
      cmd(rx_engine_pkg::CMD_IDLE);
      check({1'h0, activeCommand, commandDoneFlag}, 8'h00);
      final_report();
   end
endmodule
